// file: cpu_router_pkg.sv
// constants and types shared by the processor-side router and the processor bus agent
// assumes one system clock; both ends import this package whole
package cpu_router_pkg;

	localparam int          NUM_RANGES        = 10;
	localparam int          STRAP_WIDTH       = 16;
	localparam int          CPU_ENDIAN_STRAP  = 11;
	localparam int          PCI_ENDIAN_STRAP  = 12;

	// command lines: write flag, access size, words in a block minus one
	localparam int          CMD_WIDTH         = 6;
	localparam int          CMD_WRITE_BIT     = 5;
	localparam int          CMD_SIZE_LSB      = 3;
	localparam int          CMD_COUNT_LSB     = 0;
	localparam logic [2:0]  MAX_PCI_BURST_CNT = 3'h3;

	// write data-rate pattern: only the single D rate is supported
	localparam int          PATTERN_LSB       = 24;
	localparam logic [3:0]  D_RATE_PATTERN    = 4'h0;

	// internal register block sits at a fixed base so boot code can reach it
	localparam logic [31:0] INT_REG_BASE      = 32'h0F00_0000;
	localparam logic [31:0] INT_REG_MASK      = 32'hFFFF_F000;
	localparam logic [3:0]  CFG_PAGE          = 4'h1;
	localparam logic [7:0]  MAILBOX_PAGE      = 8'h20;

	// processor bus agent register map (byte offsets)
	localparam logic [7:0]  AGENT_ADDR_OFS    = 8'h00;
	localparam logic [7:0]  AGENT_CMD_OFS     = 8'h04;
	localparam logic [7:0]  AGENT_STATUS_OFS  = 8'h08;
	localparam logic [7:0]  AGENT_CONFIG_OFS  = 8'h0C;
	localparam logic [2:0]  AGENT_BUF_PAGE    = 3'h1;
	localparam int          STAT_BUSY_BIT     = 0;
	localparam int          STAT_DONE_BIT     = 1;
	localparam int          STAT_ERROR_BIT    = 2;
	localparam logic [31:0] CONFIG_RESET      = 32'h0000_0000;
	localparam logic [31:0] ADDR_RESET        = 32'h0000_0000;

	typedef enum logic [1:0] {
		SIZE_BYTE  = 2'b00,
		SIZE_HALF  = 2'b01,
		SIZE_WORD  = 2'b10,
		SIZE_BLOCK = 2'b11
	} size_type;

	typedef enum logic [3:0] {
		RANGE_BOOT          = 4'h0,
		RANGE_BOOT_RECOVERY = 4'h1,
		RANGE_BOOT_IO       = 4'h2,
		RANGE_INTERNAL      = 4'h3,
		RANGE_BASE          = 4'h4,
		RANGE_SIMM1         = 4'h5,
		RANGE_SIMM2         = 4'h6,
		RANGE_PCI_MEM1      = 4'h7,
		RANGE_PCI_MEM2      = 4'h8,
		RANGE_PCI_IO        = 4'h9
	} range_type;

endpackage: cpu_router_pkg

// file: cpu_link_if.sv
// link between the processor bus agent and the router
// assumes both ends run on the same sys_clk; every signal is driven by exactly one end
`timescale 1ns/1ns
`default_nettype none
interface cpu_link_if;
	import cpu_router_pkg::*;

	logic [31:0]          cpuSystemBusOut;
	logic [31:0]          cpuSystemBusIn;
	logic [CMD_WIDTH-1:0] cpuCommandLines;
	logic                 cmdValid_n;
	logic                 writeValid_n;
	logic                 externalDataValid_n;
	logic                 cpuError;
	logic [3:0]           cpuWritePatternField;

	modport device (
		input  cpuSystemBusOut,
		input  cpuCommandLines,
		input  cmdValid_n,
		input  writeValid_n,
		input  cpuWritePatternField,
		output cpuSystemBusIn,
		output externalDataValid_n,
		output cpuError
	);

	modport processor (
		output cpuSystemBusOut,
		output cpuCommandLines,
		output cmdValid_n,
		output writeValid_n,
		output cpuWritePatternField,
		input  cpuSystemBusIn,
		input  externalDataValid_n,
		input  cpuError
	);
endinterface: cpu_link_if
`default_nettype wire

// file: cpu_bus_agent.sv
// processor-side bus agent: classic Wishbone registers launch single or block cycles
// assumes a Wishbone master on sys_clk and the router on the far side of the link
`timescale 1ns/1ns
`default_nettype none
module cpu_bus_agent
	import cpu_router_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	cpu_link_if.processor    link
);

	typedef enum logic [1:0] {
		H_IDLE  = 2'b00,
		H_ADDR  = 2'b01,
		H_WRITE = 2'b10,
		H_READ  = 2'b11
	} agent_state_type;

	agent_state_type      state_reg;
	logic [31:0]          addr_reg;
	logic [31:0]          config_reg;
	logic [CMD_WIDTH-1:0] cmd_reg;
	logic [31:0]          buf_reg [8];
	logic [3:0]           idx_reg;
	logic                 done_reg;
	logic                 error_reg;
	logic                 wbAck_reg;
	logic [31:0]          wbData_reg;
	logic                 wbAccept;
	logic                 launch;
	logic [3:0]           lastIdx;

	function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] din,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (sel[i])
				r[8*i +: 8] = din[8*i +: 8];
		return r;
	endfunction: mergeBytes

	assign wbAccept = wb_cyc_i & wb_stb_i & ~wbAck_reg;
	assign launch   = wbAccept & wb_we_i & (wb_adr_i == AGENT_CMD_OFS) & (state_reg == H_IDLE);
	// single accesses carry one word; block count only counts for block size
	assign lastIdx  = (size_type'(cmd_reg[CMD_SIZE_LSB +: 2]) == SIZE_BLOCK) ?
		{1'b0, cmd_reg[CMD_COUNT_LSB +: 3]} + 4'h1 : 4'h1;
	assign wb_ack_o = wbAck_reg;
	assign wb_dat_o = wbData_reg;
	assign link.cpuWritePatternField = config_reg[PATTERN_LSB +: 4];

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wbAck_reg  <= 1'b0;
			wbData_reg <= 32'h0000_0000;
		end else begin
			wbAck_reg  <= wbAccept;
			wbData_reg <= 32'h0000_0000;
			if (wbAccept && !wb_we_i) begin
				if (wb_adr_i == AGENT_ADDR_OFS)
					wbData_reg <= addr_reg;
				else if (wb_adr_i == AGENT_CMD_OFS)
					wbData_reg <= {{(32-CMD_WIDTH){1'b0}}, cmd_reg};
				else if (wb_adr_i == AGENT_STATUS_OFS)
					wbData_reg <= {29'h0, error_reg, done_reg, state_reg != H_IDLE};
				else if (wb_adr_i == AGENT_CONFIG_OFS)
					wbData_reg <= config_reg;
				else if (wb_adr_i[7:5] == AGENT_BUF_PAGE)
					wbData_reg <= buf_reg[wb_adr_i[4:2]];
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			addr_reg   <= ADDR_RESET;
			config_reg <= CONFIG_RESET;
		end else if (wbAccept && wb_we_i) begin
			if (wb_adr_i == AGENT_ADDR_OFS)
				addr_reg <= mergeBytes(addr_reg, wb_dat_i, wb_sel_i);
			if (wb_adr_i == AGENT_CONFIG_OFS)
				config_reg <= mergeBytes(config_reg, wb_dat_i, wb_sel_i);
		end
	end

	// read data from the link takes priority over software writes to the buffer
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 8; i++)
				buf_reg[i] <= 32'h0000_0000;
		end else if (state_reg == H_READ && !link.externalDataValid_n) begin
			buf_reg[idx_reg[2:0]] <= link.cpuSystemBusIn;
		end else if (wbAccept && wb_we_i && wb_adr_i[7:5] == AGENT_BUF_PAGE) begin
			buf_reg[wb_adr_i[4:2]] <= mergeBytes(buf_reg[wb_adr_i[4:2]], wb_dat_i, wb_sel_i);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg                <= H_IDLE;
			cmd_reg                  <= '0;
			idx_reg                  <= 4'h0;
			done_reg                 <= 1'b0;
			error_reg                <= 1'b0;
			link.cmdValid_n          <= 1'b1;
			link.writeValid_n        <= 1'b1;
			link.cpuSystemBusOut     <= 32'h0000_0000;
			link.cpuCommandLines     <= '0;
		end else begin
			case (state_reg)
				H_IDLE: begin
					if (launch) begin
						cmd_reg              <= wb_dat_i[CMD_WIDTH-1:0];
						done_reg             <= 1'b0;
						error_reg            <= 1'b0;
						link.cmdValid_n      <= 1'b0;
						link.cpuSystemBusOut <= addr_reg;
						link.cpuCommandLines <= wb_dat_i[CMD_WIDTH-1:0];
						state_reg            <= H_ADDR;
					end
				end
				H_ADDR: begin
					link.cmdValid_n <= 1'b1;
					if (cmd_reg[CMD_WRITE_BIT]) begin
						// one word per cycle: the single D rate
						link.writeValid_n    <= 1'b0;
						link.cpuSystemBusOut <= buf_reg[0];
						idx_reg              <= 4'h1;
						state_reg            <= H_WRITE;
					end else begin
						idx_reg   <= 4'h0;
						state_reg <= H_READ;
					end
				end
				H_WRITE: begin
					if (link.cpuError || idx_reg == lastIdx) begin
						link.writeValid_n <= 1'b1;
						error_reg         <= link.cpuError;
						done_reg          <= 1'b1;
						state_reg         <= H_IDLE;
					end else begin
						link.cpuSystemBusOut <= buf_reg[idx_reg[2:0]];
						idx_reg              <= idx_reg + 4'h1;
					end
				end
				H_READ: begin
					if (link.cpuError) begin
						error_reg <= 1'b1;
						done_reg  <= 1'b1;
						state_reg <= H_IDLE;
					end else if (!link.externalDataValid_n) begin
						idx_reg <= idx_reg + 4'h1;
						if (idx_reg + 4'h1 == lastIdx) begin
							done_reg  <= 1'b1;
							state_reg <= H_IDLE;
						end
					end
				end
				default: state_reg <= H_IDLE;
			endcase
		end
	end

endmodule: cpu_bus_agent
`default_nettype wire

// file: cpu_port_access_router.sv
// processor-side access router: decodes processor and PCI requests onto internal targets
// assumes the agent on the link, targets answering reads with tgtReadValid, straps stable
// in reset
`timescale 1ns/1ns
`default_nettype none
module cpu_port_access_router
	import cpu_router_pkg::*;
(
	input  wire logic                   sys_clk,
	input  wire logic                   rst,
	cpu_link_if.device                  link,
	input  wire logic [STRAP_WIDTH-1:0] multiplexedAddrDataStraps,
	input  wire logic                   addOnBoardMode,
	input  wire logic [31:0]            rangeBase [NUM_RANGES],
	input  wire logic [31:0]            rangeMask [NUM_RANGES],
	output logic                        tgtReq,
	output logic                        tgtWrite,
	output logic [31:0]                 tgtAddr,
	output logic [1:0]                  tgtSize,
	output logic [31:0]                 tgtWriteData,
	output logic [NUM_RANGES-1:0]       tgtSelect,
	input  wire logic                   tgtReadValid,
	input  wire logic [31:0]            tgtReadData,
	input  wire logic                   pciReq,
	input  wire logic [31:0]            pciAddr,
	input  wire logic                   pciWrite,
	input  wire logic [1:0]             pciSize,
	output logic                        pciAck,
	output logic                        pciStop,
	output logic                        pciAbort,
	output logic                        pciCacheLineRead,
	output logic [NUM_RANGES-1:0]       pciSelect,
	output logic                        cpuBigEndian,
	output logic                        pciBigEndian
);

	typedef enum logic [1:0] {
		S_IDLE      = 2'b00,
		S_WRITE     = 2'b01,
		S_READ_REQ  = 2'b10,
		S_READ_WAIT = 2'b11
	} router_state_type;

	router_state_type    state_reg;
	logic                strapTaken_reg;
	logic [31:0]         addr_reg;
	logic [2:0]          count_reg;
	logic [2:0]          idx_reg;
	logic                swap_reg;
	logic [NUM_RANGES-1:0] cpuHit;
	logic [NUM_RANGES-1:0] pciHit;
	logic [4:0]          cpuFirst;
	logic [4:0]          pciFirst;
	logic                cmdWrite;
	size_type            cmdSize;
	logic [2:0]          cmdCount;
	logic                cmdOk;
	logic                swapNow;
	logic [31:0]         nextAddr;

	function automatic logic matchRange(input logic [31:0] a, input logic [31:0] base,
		input logic [31:0] mask);
		return (a & mask) == (base & mask);
	endfunction: matchRange

	// lowest range index wins when programmable windows overlap
	function automatic logic [4:0] firstHit(input logic [NUM_RANGES-1:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = NUM_RANGES - 1; i >= 0; i--)
			if (v[i])
				r = {1'b1, 4'(i)};
		return r;
	endfunction: firstHit

	function automatic logic [31:0] swapBytes(input logic [31:0] d);
		return {d[7:0], d[15:8], d[23:16], d[31:24]};
	endfunction: swapBytes

	function automatic logic isCfg(input logic [31:0] a);
		return a[11:8] == CFG_PAGE;
	endfunction: isCfg

	function automatic logic isMailbox(input logic [31:0] a);
		return a[11:4] == MAILBOX_PAGE;
	endfunction: isMailbox

	function automatic logic isPciWindow(input logic [3:0] r);
		return r == RANGE_PCI_MEM1 || r == RANGE_PCI_MEM2 || r == RANGE_PCI_IO;
	endfunction: isPciWindow

	for (genvar g = 0; g < NUM_RANGES; g++) begin : g_decode
		if (g == RANGE_INTERNAL) begin : g_fixed
			assign cpuHit[g] = matchRange(link.cpuSystemBusOut, INT_REG_BASE, INT_REG_MASK);
			assign pciHit[g] = matchRange(pciAddr, INT_REG_BASE, INT_REG_MASK);
		end else begin : g_prog
			assign cpuHit[g] = matchRange(link.cpuSystemBusOut, rangeBase[g], rangeMask[g]);
			assign pciHit[g] = matchRange(pciAddr, rangeBase[g], rangeMask[g]);
		end
	end

	assign cpuFirst = firstHit(cpuHit);
	assign pciFirst = firstHit(pciHit);
	assign cmdWrite = link.cpuCommandLines[CMD_WRITE_BIT];
	assign cmdSize  = size_type'(link.cpuCommandLines[CMD_SIZE_LSB +: 2]);
	assign cmdCount = (cmdSize == SIZE_BLOCK) ? link.cpuCommandLines[CMD_COUNT_LSB +: 3] : 3'h0;
	// internal data stays little-endian; swap only toward a big-endian processor or PCI
	assign swapNow  = cpuBigEndian ^ (pciBigEndian & isPciWindow(cpuFirst[3:0]));
	assign nextAddr = addr_reg + {27'h0, idx_reg + 3'h1, 2'b00};

	// legality of a processor access by target, size, direction and alignment
	always_comb begin
		logic aligned;
		aligned = 1'b1;
		cmdOk   = 1'b0;
		if (cmdSize == SIZE_HALF)
			aligned = ~link.cpuSystemBusOut[0];
		else if (cmdSize != SIZE_BYTE)
			aligned = link.cpuSystemBusOut[1:0] == 2'b00;
		if (cpuFirst[4]) begin
			case (range_type'(cpuFirst[3:0]))
				RANGE_BOOT, RANGE_BOOT_RECOVERY, RANGE_BOOT_IO:
					cmdOk = aligned & (cmdWrite ? cmdSize == SIZE_BYTE : cmdSize != SIZE_BLOCK);
				RANGE_INTERNAL:
					if (isCfg(link.cpuSystemBusOut))
						cmdOk = aligned & (cmdSize != SIZE_BLOCK);
					else
						cmdOk = aligned & (cmdSize == SIZE_WORD);
				RANGE_BASE, RANGE_SIMM1, RANGE_SIMM2:
					cmdOk = aligned;
				RANGE_PCI_MEM1, RANGE_PCI_MEM2, RANGE_PCI_IO:
					cmdOk = aligned & (cmdCount <= MAX_PCI_BURST_CNT);
				default:
					cmdOk = 1'b0;
			endcase
		end
		// a write pattern other than the single D rate cannot be paced
		if (cmdWrite && link.cpuWritePatternField != D_RATE_PATTERN)
			cmdOk = 1'b0;
	end

	// straps are caught on the first edge after reset release, never by the reset itself
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			strapTaken_reg <= 1'b0;
			cpuBigEndian   <= 1'b0;
			pciBigEndian   <= 1'b0;
		end else if (!strapTaken_reg) begin
			strapTaken_reg <= 1'b1;
			cpuBigEndian   <= multiplexedAddrDataStraps[CPU_ENDIAN_STRAP];
			pciBigEndian   <= multiplexedAddrDataStraps[PCI_ENDIAN_STRAP];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg                <= S_IDLE;
			addr_reg                 <= 32'h0000_0000;
			count_reg                <= 3'h0;
			idx_reg                  <= 3'h0;
			swap_reg                 <= 1'b0;
			tgtReq                   <= 1'b0;
			tgtWrite                 <= 1'b0;
			tgtAddr                  <= 32'h0000_0000;
			tgtSize                  <= 2'b00;
			tgtWriteData             <= 32'h0000_0000;
			tgtSelect                <= '0;
			link.cpuSystemBusIn      <= 32'h0000_0000;
			link.externalDataValid_n <= 1'b1;
			link.cpuError            <= 1'b0;
		end else begin
			tgtReq                   <= 1'b0;
			link.externalDataValid_n <= 1'b1;
			link.cpuError            <= 1'b0;
			case (state_reg)
				S_IDLE: begin
					if (!link.cmdValid_n) begin
						if (cmdOk) begin
							addr_reg  <= link.cpuSystemBusOut;
							count_reg <= cmdCount;
							idx_reg   <= 3'h0;
							swap_reg  <= swapNow;
							tgtWrite  <= cmdWrite;
							tgtAddr   <= link.cpuSystemBusOut;
							tgtSize   <= cmdSize;
							tgtSelect <= NUM_RANGES'(1) << cpuFirst[3:0];
							state_reg <= cmdWrite ? S_WRITE : S_READ_REQ;
						end else begin
							link.cpuError <= 1'b1;
						end
					end
				end
				S_WRITE: begin
					if (!link.writeValid_n) begin
						tgtReq       <= 1'b1;
						tgtAddr      <= addr_reg + {27'h0, idx_reg, 2'b00};
						tgtWriteData <= swap_reg ? swapBytes(link.cpuSystemBusOut)
							: link.cpuSystemBusOut;
						idx_reg      <= idx_reg + 3'h1;
						if (idx_reg == count_reg)
							state_reg <= S_IDLE;
					end
				end
				S_READ_REQ: begin
					tgtReq    <= 1'b1;
					state_reg <= S_READ_WAIT;
				end
				S_READ_WAIT: begin
					if (tgtReadValid) begin
						link.cpuSystemBusIn      <= swap_reg ? swapBytes(tgtReadData)
							: tgtReadData;
						link.externalDataValid_n <= 1'b0;
						idx_reg                  <= idx_reg + 3'h1;
						tgtAddr                  <= nextAddr;
						state_reg                <= (idx_reg == count_reg) ? S_IDLE : S_READ_REQ;
					end
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	// PCI-side claim: one registered answer per request
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pciAck           <= 1'b0;
			pciStop          <= 1'b0;
			pciAbort         <= 1'b0;
			pciCacheLineRead <= 1'b0;
			pciSelect        <= '0;
		end else begin
			pciAck           <= 1'b0;
			pciStop          <= 1'b0;
			pciAbort         <= 1'b0;
			pciCacheLineRead <= 1'b0;
			pciSelect        <= '0;
			if (pciReq) begin
				pciAbort <= 1'b1;
				if (pciFirst[4]) begin
					case (range_type'(pciFirst[3:0]))
						RANGE_BASE, RANGE_SIMM1, RANGE_SIMM2: begin
							pciAbort         <= 1'b0;
							pciAck           <= 1'b1;
							// disconnect while the processor path owns the targets
							pciStop          <= state_reg != S_IDLE;
							pciCacheLineRead <= ~pciWrite;
							pciSelect        <= NUM_RANGES'(1) << pciFirst[3:0];
						end
						RANGE_INTERNAL: begin
							if (isMailbox(pciAddr) && pciSize == SIZE_WORD) begin
								pciAbort         <= 1'b0;
								pciAck           <= 1'b1;
								pciStop          <= 1'b1;
								pciCacheLineRead <= ~pciWrite;
								pciSelect        <= NUM_RANGES'(1) << pciFirst[3:0];
							end else if (isCfg(pciAddr) && addOnBoardMode
								&& pciSize != SIZE_BLOCK) begin
								pciAbort         <= 1'b0;
								pciAck           <= 1'b1;
								pciCacheLineRead <= ~pciWrite;
								pciSelect        <= NUM_RANGES'(1) << pciFirst[3:0];
							end
							// all other internal registers stay hidden
						end
						// boot ROM and PCI windows are never claimed
						default: pciAbort <= 1'b1;
					endcase
				end
			end
		end
	end

endmodule: cpu_port_access_router
`default_nettype wire

// file: cpu_link_monitor.sv
// checker for the link between the processor bus agent and the router
// assumes the testbench instantiates it beside the link, on sys_clk and rst
`timescale 1ns/1ns
`default_nettype none
module cpu_link_monitor
	import cpu_router_pkg::*;
(
	input wire logic                 sys_clk,
	input wire logic                 rst,
	input wire logic [31:0]          cpuSystemBusOut,
	input wire logic [CMD_WIDTH-1:0] cpuCommandLines,
	input wire logic                 cmdValid_n,
	input wire logic                 externalDataValid_n,
	input wire logic                 cpuError,
	input wire logic [3:0]           cpuWritePatternField
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic       inBlock;
	logic       cfgPage;
	logic [1:0] size;
	logic       cmdIn;
	assign inBlock = (cpuSystemBusOut & INT_REG_MASK) == INT_REG_BASE;
	assign cfgPage = inBlock && cpuSystemBusOut[11:8] == CFG_PAGE;
	assign size = cpuCommandLines[CMD_SIZE_LSB +: 2];
	// only plain commands count; a bad pattern refuses every write
	assign cmdIn = !cmdValid_n && cpuWritePatternField == D_RATE_PATTERN;
	property p_pattern;
		!cmdValid_n && cpuWritePatternField != D_RATE_PATTERN |=> cpuError;
	endproperty
	a_pattern: assert property (p_pattern) else $error("pattern not refused");
	property p_dvalidPulse;
		!externalDataValid_n |=> externalDataValid_n;
	endproperty
	a_dvalidPulse: assert property (p_dvalidPulse) else $error("data valid too long");
	property p_errNoData;
		cpuError |-> externalDataValid_n ##1 externalDataValid_n;
	endproperty
	a_errNoData: assert property (p_errNoData) else $error("data after refusal");
	property p_errCause;
		cpuError |-> $past(cmdValid_n) == 1'b0;
	endproperty
	a_errCause: assert property (p_errCause) else $error("refusal without command");
	property p_cmdPulse;
		!cmdValid_n |=> cmdValid_n [*2];
	endproperty
	a_cmdPulse: assert property (p_cmdPulse) else $error("address cycle too long");
	property p_intNarrow;
		cmdIn && inBlock && !cfgPage && size != SIZE_WORD |=> cpuError;
	endproperty
	a_intNarrow: assert property (p_intNarrow) else $error("narrow register access taken");
	property p_intWord;
		cmdIn && inBlock && size == SIZE_WORD && cpuSystemBusOut[1:0] == 2'b00 |=> !cpuError;
	endproperty
	a_intWord: assert property (p_intWord) else $error("fixed register block refused");
	property p_cfgByte;
		cmdIn && cfgPage && size == SIZE_BYTE |=> !cpuError;
	endproperty
	a_cfgByte: assert property (p_cfgByte) else $error("config byte refused");
endmodule: cpu_link_monitor
`default_nettype wire

// file: testbench.sv
// self-checking bench: agent and router joined by the link; targets and pci side modelled here
// assumes the package and the link interface are compiled first
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import cpu_router_pkg::*;
	logic        sys_clk = 0;
	logic        rst = 1;
	logic [7:0]  adr = 0;
	logic [31:0] wdat = 0;
	logic        we = 0;
	logic        cyc = 0;
	logic        stb = 0;
	logic [31:0] rdat, rd, tAddr, tWd, lastData, lastAddr;
	logic        ack, tReq, tWr, cpuBig, pciBig;
	logic        addOn = 0;
	logic [15:0] straps = 16'h0800;
	logic        tRv = 0;
	logic [31:0] tRd = 0;
	logic [31:0] rBase [NUM_RANGES];
	logic [31:0] rMask [NUM_RANGES];
	logic [1:0]  tSize;
	logic [9:0]  tSel, lastSel;
	logic        pReq = 0;
	logic        pWr = 0;
	logic [31:0] pAddr = 0;
	logic [1:0]  pSize = 0;
	logic        pAck, pStop, pAbort, pCl;
	logic [3:0]  pFl = 0;
	int          nReq = 0;
	int          n0, cycles = 0;
	int          err_total = 0;
	int          tests_run = 0;
	cpu_link_if link();
	cpu_bus_agent i_cpu_bus_agent(.sys_clk(sys_clk), .rst(rst), .wb_adr_i(adr), .wb_dat_i(wdat),
		.wb_we_i(we), .wb_sel_i(4'hF), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
		.wb_ack_o(ack), .link(link));
	cpu_port_access_router i_cpu_port_access_router(.sys_clk(sys_clk), .rst(rst), .link(link),
		.multiplexedAddrDataStraps(straps), .addOnBoardMode(addOn), .rangeBase(rBase),
		.rangeMask(rMask), .tgtReq(tReq), .tgtWrite(tWr), .tgtAddr(tAddr), .tgtSize(tSize),
		.tgtWriteData(tWd), .tgtSelect(tSel), .tgtReadValid(tRv), .tgtReadData(tRd),
		.pciReq(pReq), .pciAddr(pAddr), .pciWrite(pWr), .pciSize(pSize), .pciAck(pAck),
		.pciStop(pStop), .pciAbort(pAbort), .pciCacheLineRead(pCl), .pciSelect(),
		.cpuBigEndian(cpuBig), .pciBigEndian(pciBig));
	cpu_link_monitor i_cpu_link_monitor(.sys_clk(sys_clk), .rst(rst),
		.cpuSystemBusOut(link.cpuSystemBusOut), .cpuCommandLines(link.cpuCommandLines),
		.cmdValid_n(link.cmdValid_n), .externalDataValid_n(link.externalDataValid_n),
		.cpuError(link.cpuError), .cpuWritePatternField(link.cpuWritePatternField));
	always #5 sys_clk = ~sys_clk;
	// targets answer every read one cycle after the request
	always @(posedge sys_clk) begin
		tRv <= tReq && !tWr;
		tRd <= 32'hA1B2_C3D4;
	end
	always @(posedge sys_clk) begin
		cycles = cycles + 1;
		if (tReq === 1'b1) begin
			nReq = nReq + 1;
			lastData = tWd;
			lastAddr = tAddr;
			lastSel = tSel;
		end
		pFl = pFl | {pAck, pStop, pAbort, pCl};
		if (cycles == 20000) begin
			err_total++;
			conclude();
		end
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask: conclude
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask: chk
	task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic w);
		@(posedge sys_clk);
		adr <= a;
		wdat <= d;
		we <= w;
		cyc <= 1'b1;
		stb <= 1'b1;
		// ack and read data are taken at the rising edge that sees ack high
		do @(posedge sys_clk); while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask: wb
	// one link command through the agent, then poll until it is no longer busy
	task automatic run(input logic [31:0] a, input logic [5:0] c, input logic [31:0] d);
		n0 = nReq;
		wb(AGENT_ADDR_OFS, a, 1'b1);
		for (int i = 0; i <= int'(c[2:0]); i++) wb({AGENT_BUF_PAGE, 3'(i), 2'b00}, d, 1'b1);
		wb(AGENT_CMD_OFS, {26'h0, c}, 1'b1);
		rd = 32'h1;
		while (rd[STAT_BUSY_BIT] !== 1'b0) wb(AGENT_STATUS_OFS, 32'h0, 1'b0);
	endtask: run
	task automatic res(input int dn, input logic err);
		chk("requests", 32'(nReq - n0), 32'(dn));
		chk("error flag", {31'h0, rd[STAT_ERROR_BIT]}, {31'h0, err});
	endtask: res
	task automatic pci(input logic [31:0] a, input logic [1:0] s, input logic w,
		input logic [3:0] e);
		@(posedge sys_clk);
		pAddr <= a;
		pSize <= s;
		pWr <= w;
		pReq <= 1'b1;
		pFl = 4'h0;
		@(posedge sys_clk);
		pReq <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk("pci answer", {28'h0, pFl}, {28'h0, e});
	endtask: pci
	task automatic t_reset();
		chk("cpu order", {31'h0, cpuBig}, 32'h1);
		chk("pci order", {31'h0, pciBig}, 32'h0);
		wb(AGENT_CONFIG_OFS, 32'h0, 1'b0);
		chk("config", rd, CONFIG_RESET);
		wb(8'h18, 32'h0, 1'b0);
		chk("unmapped", rd, 32'h0);
		$display("test reset done");
	endtask: t_reset
	task automatic t_write();
		run(32'h1400_0010, {1'b1, SIZE_WORD, 3'h0}, 32'h0102_0304);
		res(1, 1'b0);
		chk("select", {22'h0, lastSel}, 32'h10);
		chk("swapped", lastData, 32'h0403_0201);
		run(32'h1000_0003, {1'b1, SIZE_BYTE, 3'h0}, 32'hAA);
		res(1, 1'b0);
		chk("boot select", {22'h0, lastSel}, 32'h1);
		run(32'h1000_0002, {1'b1, SIZE_HALF, 3'h0}, 32'hBB);
		res(0, 1'b1);
		$display("test write done");
	endtask: t_write
	task automatic t_read();
		run(32'h0F00_0004, {1'b0, SIZE_WORD, 3'h0}, 32'h0);
		res(1, 1'b0);
		chk("internal select", {22'h0, lastSel}, 32'h8);
		wb({AGENT_BUF_PAGE, 5'h0}, 32'h0, 1'b0);
		chk("read data", rd, 32'hD4C3_B2A1);
		run(32'h0F00_0004, {1'b0, SIZE_HALF, 3'h0}, 32'h0);
		res(0, 1'b1);
		run(32'h1000_0002, {1'b0, SIZE_HALF, 3'h0}, 32'h0);
		res(1, 1'b0);
		run(32'h0F00_0101, {1'b0, SIZE_BYTE, 3'h0}, 32'h0);
		res(1, 1'b0);
		$display("test read done");
	endtask: t_read
	task automatic t_burst();
		wb(AGENT_CONFIG_OFS, 32'h0100_0000, 1'b1);
		run(32'h1400_0000, {1'b1, SIZE_WORD, 3'h0}, 32'h5);
		res(0, 1'b1);
		wb(AGENT_CONFIG_OFS, 32'h0, 1'b1);
		run(32'h1700_0000, {1'b1, SIZE_BLOCK, 3'h7}, 32'h6);
		res(0, 1'b1);
		run(32'h1700_0000, {1'b1, SIZE_BLOCK, 3'h3}, 32'h7);
		res(4, 1'b0);
		chk("last word", lastAddr, 32'h1700_000C);
		run(32'h1400_0000, {1'b1, SIZE_BLOCK, 3'h7}, 32'h8);
		res(8, 1'b0);
		$display("test burst done");
	endtask: t_burst
	task automatic t_pci();
		pci(32'h1000_0000, SIZE_WORD, 1'b0, 4'b0010);
		pci(32'h1700_0000, SIZE_WORD, 1'b1, 4'b0010);
		pci(32'h1400_0000, SIZE_WORD, 1'b0, 4'b1001);
		pci(32'h1400_0001, SIZE_BYTE, 1'b1, 4'b1000);
		pci(32'h0F00_0200, SIZE_WORD, 1'b1, 4'b1100);
		pci(32'h0F00_0200, SIZE_HALF, 1'b1, 4'b0010);
		pci(32'h0F00_0000, SIZE_WORD, 1'b1, 4'b0010);
		pci(32'h0F00_0100, SIZE_BYTE, 1'b1, 4'b0010);
		addOn <= 1'b1;
		pci(32'h0F00_0100, SIZE_BYTE, 1'b1, 4'b1000);
		$display("test pci done");
	endtask: t_pci
	// second reset with the other strap levels: only the pci window is swapped now
	task automatic t_strap();
		rst <= 1'b1;
		straps <= 16'h1000;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk("cpu order 2", {31'h0, cpuBig}, 32'h0);
		chk("pci order 2", {31'h0, pciBig}, 32'h1);
		run(32'h1700_0000, {1'b1, SIZE_WORD, 3'h0}, 32'h0102_0304);
		res(1, 1'b0);
		chk("window swap", lastData, 32'h0403_0201);
		run(32'h1400_0000, {1'b1, SIZE_WORD, 3'h0}, 32'h0102_0304);
		res(1, 1'b0);
		chk("memory order", lastData, 32'h0102_0304);
		$display("test strap done");
	endtask: t_strap
	initial begin
		for (int g = 0; g < NUM_RANGES; g++) begin
			rBase[g] = 32'h1000_0000 + (32'(g) << 24);
			rMask[g] = 32'hFF00_0000;
		end
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (3) @(posedge sys_clk);
		t_reset();
		t_write();
		t_read();
		t_burst();
		t_pci();
		t_strap();
		conclude();
	end
endmodule: testbench
`default_nettype wire
